//--- common/log_cmd_pkg.sv
// Constants shared by the extended read-log command handler.
package log_cmd_pkg;
	localparam logic [7:0]  CMD_READ_LOG_EXT  = 8'h2F;
	localparam logic [7:0]  LOG_DIRECTORY     = 8'h00;
	localparam logic [7:0]  LOG_EXT_ERROR     = 8'h03;
	localparam logic [7:0]  LOG_SELFTEST_BASE = 8'h06;
	localparam logic [7:0]  LOG_SELFTEST_EXT  = 8'h07;
	localparam logic [7:0]  LOG_POWER_COND    = 8'h08;
	localparam logic [7:0]  LOG_QUEUED_ERROR  = 8'h10;
	localparam logic [7:0]  LOG_LINK_EVENTS   = 8'h11;
	localparam logic [7:0]  LOG_QUEUE_MGMT    = 8'h12;
	localparam logic [7:0]  LOG_REBUILD       = 8'h15;
	localparam logic [7:0]  LOG_STREAM_WRITE  = 8'h21;
	localparam logic [7:0]  LOG_STREAM_READ   = 8'h22;
	localparam logic [7:0]  LOG_IDENTIFY      = 8'h30;
	localparam logic [2:0]  VENDOR_TOP        = 3'h4;
	localparam logic [15:0] VENDOR_SECTORS    = 16'h0010;
	localparam logic [15:0] PLAIN_SECTORS     = 16'h0001;
	localparam logic [15:0] DIR_VERSION       = 16'h0001;
	localparam logic [15:0] NO_SECTORS        = 16'h0000;
	localparam logic [7:0]  LAST_WORD         = 8'hFF;
	// Feature-set enable positions.
	localparam int FE_ERROR_LOG = 0;
	localparam int FE_SELFTEST  = 1;
	localparam int FE_POWER     = 2;
	localparam int FE_QUEUING   = 3;
	localparam int FE_LINK_EVT  = 4;
	localparam int FE_QUEUE_MGT = 5;
	localparam int FE_STREAM    = 6;
	localparam int FE_REBUILD   = 7;
	localparam int FE_SMART     = 8;
	localparam int FE_W         = 9;
	// Error flag positions.
	localparam int ERR_UNC = 6;
	localparam int ERR_IDN = 4;
	localparam int ERR_ABT = 2;
	// Completion flag positions.
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DF  = 5;
	localparam int ST_DSC = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	localparam logic [7:0] STATUS_RESET = 8'h50;
	localparam logic [7:0] ERROR_RESET  = 8'h00;
	// Word store address: slot, sector within log, word within sector.
	localparam int SLOT_W  = 6;
	localparam int STORE_AW = 18;
	localparam int WORD_W  = 16;
	localparam int FIFO_DEPTH = 8;
	localparam logic [5:0] VENDOR_SLOT_BASE = 6'h10;
endpackage

//--- common/word_stream_if.sv
// Valid/ready word stream between the handler and its buffer.
`timescale 1ns/1ps
interface word_stream_if;
	logic        valid;
	logic        ready;
	logic [15:0] data;
	logic        drained;
	modport src (output valid, output data, input ready, input drained);
	modport snk (input valid, input data, output ready, output drained);
endinterface

//--- dv/host_sink.sv
// Host-side sink model that takes returned log words and counts block interrupts.
`timescale 1ns/1ps
module host_sink
	import log_cmd_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              slow,
	input  wire logic              data_valid,
	input  wire logic [WORD_W-1:0] data_word,
	input  wire logic              irq,
	output logic                   data_ready
);
	import log_cmd_pkg::*;
	logic [1:0]        phase;
	logic [WORD_W-1:0] words[$];
	int                irqs;

	// A slow host takes one word in four, so the buffer fills and must hold back.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end

	assign data_ready = rst_n && (!slow || phase == 2'h3);

	always @(posedge clk)
	begin
		if (rst_n && data_valid === 1'b1 && data_ready)
			words.push_back(data_word);
		if (rst_n && irq === 1'b1)
			irqs++;
	end
endmodule

//--- dv/read_log_ext_command_handler_tb.sv
// Self-checking bench for the extended read-log command handler.
`timescale 1ns/1ps
module read_log_ext_command_handler_tb;
	import log_cmd_pkg::*;
	logic                clk, rst_n, ce, cmd_strobe, media_fault, log_wr_en, data_valid, data_ready, irq, slow;
	logic [7:0]          cmd_code, count_cur, count_prev, sector_cur, cyl_low_cur, cyl_low_prev;
	logic [7:0]          err_flags, status_flags, first_status;
	logic [FE_W-1:0]     feature_enable;
	logic [STORE_AW-1:0] log_wr_addr;
	logic [WORD_W-1:0]   log_wr_data, data_word;
	int                  fails, compares;
	logic [7:0]          lgs[10] = '{8'h03, 8'h07, 8'h08, 8'h10, 8'h11, 8'h12, 8'h15, 8'h21, 8'h22, 8'h30};
	logic [5:0]          slots[10] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A};

	read_log_ext_command_handler read_log_ext_command_handler_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
		.cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .count_cur(count_cur), .count_prev(count_prev),
		.sector_cur(sector_cur), .cyl_low_cur(cyl_low_cur), .cyl_low_prev(cyl_low_prev),
		.feature_enable(feature_enable), .media_fault(media_fault), .log_wr_en(log_wr_en),
		.log_wr_addr(log_wr_addr), .log_wr_data(log_wr_data), .data_valid(data_valid), .data_word(data_word),
		.data_ready(data_ready), .irq(irq), .command_error_flags(err_flags),
		.command_completion_flags(status_flags));

	host_sink host_sink_inst (.clk(clk), .rst_n(rst_n), .slow(slow), .data_valid(data_valid),
		.data_word(data_word), .irq(irq), .data_ready(data_ready));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [15:0] pat(input logic [5:0] s, input logic [3:0] sec, input logic [7:0] w);
		return {s, sec[1:0], w};
	endfunction

	function automatic logic [15:0] fw(input int i, input logic [7:0] w);
		return pat(slots[i], 4'h0, w);
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude;
		$display("%0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Every word carries its slot and the low two bits of its sector so a misplaced start shows in the data.
	task automatic load(input logic [5:0] s, input logic [3:0] sec);
		for (int w = 0; w < 256; w++)
		begin
			@(posedge clk);
			log_wr_en   <= 1'b1;
			log_wr_addr <= {s, sec, w[7:0]};
			log_wr_data <= pat(s, sec, w[7:0]);
		end
		@(posedge clk);
		log_wr_en <= 1'b0;
	endtask

	task automatic run(input logic [7:0] code, lg, input logic [15:0] cnt, st, input logic [FE_W-1:0] fe);
		host_sink_inst.words.delete();
		host_sink_inst.irqs = 0;
		@(posedge clk);
		feature_enable                 <= fe;
		cmd_code                       <= code;
		sector_cur                     <= lg;
		{count_prev, count_cur}       <= cnt;
		{cyl_low_prev, cyl_low_cur}   <= st;
		cmd_strobe                     <= 1'b1;
		@(posedge clk);
		cmd_strobe <= 1'b0;
		repeat (2) @(posedge clk);
		#1 first_status = status_flags;
		for (int i = 0; i < 20000 && (status_flags[ST_BSY] !== 1'b0 || status_flags[ST_DRQ] !== 1'b0); i++)
		begin
			@(posedge clk);
			#1;
		end
		check("command ended", 16'(status_flags[ST_BSY] | status_flags[ST_DRQ]), 16'h0000);
	endtask

	task automatic bad(input logic [7:0] lg, input logic [15:0] cnt, st, input logic [FE_W-1:0] fe,
		input logic [7:0] e);
		run(CMD_READ_LOG_EXT, lg, cnt, st, fe);
		check("abort status", status_flags, 8'h51);
		check("abort error", err_flags, e);
		check("abort words", 16'(host_sink_inst.words.size()), 16'h0000);
	endtask

	task automatic good(input logic [7:0] lg, input logic [15:0] cnt, st, w0, wl);
		run(CMD_READ_LOG_EXT, lg, cnt, st, '1);
		check("accept status", first_status, 8'h58);
		check("final status", status_flags, 8'h50);
		check("final error", err_flags, 8'h00);
		check("interrupts", 16'(host_sink_inst.irqs), cnt);
		check("word count", 16'(host_sink_inst.words.size()), 16'(cnt * 256));
		check("first word", host_sink_inst.words[0], w0);
		check("last word", host_sink_inst.words[$], wl);
	endtask

	initial
	begin
		{rst_n, cmd_strobe, media_fault, log_wr_en, slow, cmd_code, count_cur, count_prev} = '0;
		{sector_cur, cyl_low_cur, cyl_low_prev, log_wr_addr, log_wr_data} = '0;
		ce             = 1'b1;
		feature_enable = '1;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 check("reset status", status_flags, STATUS_RESET);
		check("reset error", err_flags, ERROR_RESET);
		check("reset valid", data_valid, 1'b0);
		$display("test reset done");

		bad(8'h06, 1, 0, '1, 8'h04);
		bad(8'h13, 1, 0, '1, 8'h04);
		bad(8'h14, 1, 0, '1, 8'h04);
		bad(8'h16, 1, 0, '1, 8'h04);
		bad(8'h17, 1, 0, '1, 8'h04);
		bad(8'h03, 0, 0, '1, 8'h04);
		bad(8'h03, 1, 1, '1, 8'h14);
		bad(8'h80, 15, 2, '1, 8'h04);
		bad(8'h03, 1, 0, 9'h1FE, 8'h04);
		bad(8'h80, 1, 0, 9'h0FF, 8'h04);
		$display("test aborts done");

		for (int i = 0; i < 10; i++)
		begin
			load(slots[i], 4'h0);
			good(lgs[i], 1, 0, fw(i, 8'h00), fw(i, 8'hFF));
		end
		// The self-test slot is shared with the basic log, so its entries show in the extended one.
		good(LOG_SELFTEST_EXT, 1, 0, fw(1, 8'h00), fw(1, 8'hFF));
		$display("test served logs done");

		// The host stalls here so the buffer backs up while two sectors stream out.
		load(6'h10, 4'h2);
		load(6'h10, 4'h3);
		load(6'h2F, 4'hF);
		slow <= 1'b1;
		good(8'h80, 2, 2, pat(6'h10, 4'h2, 8'h00), pat(6'h10, 4'h3, 8'hFF));
		good(8'h9F, 1, 15, pat(6'h2F, 4'hF, 8'h00), pat(6'h2F, 4'hF, 8'hFF));
		slow <= 1'b0;
		$display("test vendor logs done");

		good(8'h00, 1, 0, DIR_VERSION, NO_SECTORS);
		check("dir 03h", host_sink_inst.words[8'h03], PLAIN_SECTORS);
		check("dir 06h", host_sink_inst.words[8'h06], NO_SECTORS);
		check("dir 10h", host_sink_inst.words[8'h10], PLAIN_SECTORS);
		check("dir 13h", host_sink_inst.words[8'h13], NO_SECTORS);
		check("dir 15h", host_sink_inst.words[8'h15], PLAIN_SECTORS);
		check("dir 21h", host_sink_inst.words[8'h21], PLAIN_SECTORS);
		check("dir 30h", host_sink_inst.words[8'h30], PLAIN_SECTORS);
		check("dir 80h", host_sink_inst.words[8'h80], VENDOR_SECTORS);
		run(8'h25, 8'h03, 1, 0, '1);
		check("other code status", status_flags, 8'h50);
		check("other code words", 16'(host_sink_inst.words.size()), 16'h0000);
		$display("test directory done");

		// A strobe seen while the clock enable is low must leave no trace.
		@(posedge clk);
		ce <= 1'b0;
		run(CMD_READ_LOG_EXT, 8'h03, 1, 0, '1);
		@(posedge clk);
		ce <= 1'b1;
		#1 check("frozen status", status_flags, 8'h50);
		check("frozen words", 16'(host_sink_inst.words.size()), 16'h0000);
		$display("test clock enable done");

		slow <= 1'b1;
		fork
			run(CMD_READ_LOG_EXT, 8'h80, 2, 2, '1);
			begin
				repeat (40) @(posedge clk);
				media_fault <= 1'b1;
			end
		join
		@(posedge clk);
		media_fault <= 1'b0;
		slow        <= 1'b0;
		#1 check("fault status", status_flags, 8'h51);
		check("fault error", err_flags, 8'h40);
		check("fault cut short", 16'(host_sink_inst.words.size() < 512), 16'h0001);
		$display("test media fault done");
		conclude();
	end

	// The tests need about 13000 cycles; the limit leaves more than twice that.
	initial
	begin
		repeat (40000) @(posedge clk);
		fails++;
		conclude();
	end
endmodule

//--- hw/log_word_store.sv
// Word memory holding the stored log contents, read data registered.
`timescale 1ns/1ps
module log_word_store
	import log_cmd_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                ce,
	input  wire logic                wr_en,
	input  wire logic [STORE_AW-1:0] wr_addr,
	input  wire logic [WORD_W-1:0]   wr_data,
	input  wire logic                rd_en,
	input  wire logic [STORE_AW-1:0] rd_addr,
	output logic      [WORD_W-1:0]   rd_data
);
	logic [WORD_W-1:0] words [2**STORE_AW];

	always_ff @(posedge clk)
	begin
		if (ce && wr_en)
			words[wr_addr] <= wr_data;
	end

	always_ff @(posedge clk)
	begin
		if (ce && rd_en)
			rd_data <= words[rd_addr];
	end
endmodule

//--- hw/read_log_ext_command_handler.sv
// Extended read-log command handler: decode, check, and return log sectors.
// Functional notes
// - Command 2Fh returns the log selected by the log-address field.
// - One host interrupt is raised for every data block sent.
// - Returned data starts at the requested starting sector.
// - Directory at 00h and extended error log at 03h are served read-only.
// - Extended self-test log at 07h is served read-only.
// - Identification data log at 30h is served read-only.
// - Queued error, link event and queue management logs sit at 10h, 11h, 12h.
// - Streaming write and read error logs sit at 21h and 22h.
// - Requests for log 06h are aborted.
// - Logs of unsupported or disabled feature sets are aborted.
// - Invalid count, log address or start sector aborts the command.
// - Extended self-test log holds both 48-bit and 28-bit entries.
// - Basic self-test entries also appear in the extended self-test log.
// - Vendor logs 80h to 9Fh are sixteen sectors each.
// - Directory version word reads 0001h.
`timescale 1ns/1ps
module read_log_ext_command_handler
	import log_cmd_pkg::*;
(
	input  wire logic                             clk,
	input  wire logic                             rst_n,
	input  wire logic                             ce,
	input  wire logic                             cmd_strobe,
	input  wire logic [7:0]                       cmd_code,
	input  wire logic [7:0]                       count_cur,
	input  wire logic [7:0]                       count_prev,
	input  wire logic [7:0]                       sector_cur,
	input  wire logic [7:0]                       cyl_low_cur,
	input  wire logic [7:0]                       cyl_low_prev,
	input  wire logic [log_cmd_pkg::FE_W-1:0]     feature_enable,
	input  wire logic                             media_fault,
	input  wire logic                             log_wr_en,
	input  wire logic [log_cmd_pkg::STORE_AW-1:0] log_wr_addr,
	input  wire logic [log_cmd_pkg::WORD_W-1:0]   log_wr_data,
	output logic                                  data_valid,
	output logic [log_cmd_pkg::WORD_W-1:0]        data_word,
	input  wire logic                             data_ready,
	output logic                                  irq,
	output logic [7:0]                            command_error_flags,
	output logic [7:0]                            command_completion_flags
);
	import log_cmd_pkg::*;

	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_CHECK = 5'b00010,
		S_BLOCK = 5'b00100,
		S_FETCH = 5'b01000,
		S_DRAIN = 5'b10000
	} state_t;

	state_t                state;
	logic   [7:0]          log_addr;
	logic   [15:0]         start_sect;
	logic   [15:0]         sect_count;
	logic   [15:0]         sect;
	logic   [15:0]         remain;
	logic   [7:0]          widx;
	logic                  pend;
	logic                  pend_dir;
	logic                  pend_ver;
	logic   [WORD_W-1:0]   dir_q;
	logic   [WORD_W-1:0]   mem_q;
	logic                  unc_seen;
	logic                  accept;
	logic                  issue;
	logic                  last_word;
	logic                  bad_params;
	logic   [15:0]         log_len;
	logic   [STORE_AW-1:0] rd_addr;
	logic                  in_block;
	word_stream_if         fill ();

	// Whether a log address is served, given the feature-set enables.
	function automatic logic log_ok(input logic [7:0] la, input logic [FE_W-1:0] fe);
		logic ok;
		ok = 1'b0;
		if (la[7:5] == VENDOR_TOP)
			ok = fe[FE_SMART];
		else
			case (la)
				LOG_DIRECTORY:    ok = 1'b1;
				LOG_EXT_ERROR:    ok = fe[FE_ERROR_LOG];
				LOG_SELFTEST_EXT: ok = fe[FE_SELFTEST];
				LOG_POWER_COND:   ok = fe[FE_POWER];
				LOG_QUEUED_ERROR: ok = fe[FE_QUEUING];
				LOG_LINK_EVENTS:  ok = fe[FE_LINK_EVT];
				LOG_QUEUE_MGMT:   ok = fe[FE_QUEUE_MGT];
				LOG_REBUILD:      ok = fe[FE_REBUILD];
				LOG_STREAM_WRITE: ok = fe[FE_STREAM];
				LOG_STREAM_READ:  ok = fe[FE_STREAM];
				LOG_IDENTIFY:     ok = 1'b1;
				default:          ok = 1'b0;
			endcase
		return ok;
	endfunction

	// Length in sectors of a served log; zero for an unserved one.
	function automatic logic [15:0] log_size(input logic [7:0] la, input logic [FE_W-1:0] fe);
		logic [15:0] n;
		n = NO_SECTORS;
		if (log_ok(la, fe))
			n = (la[7:5] == VENDOR_TOP) ? VENDOR_SECTORS : PLAIN_SECTORS;
		return n;
	endfunction

	// Slot of a log in the word store.
	function automatic logic [SLOT_W-1:0] log_slot(input logic [7:0] la);
		logic [SLOT_W-1:0] s;
		s = '0;
		if (la[7:5] == VENDOR_TOP)
			s = VENDOR_SLOT_BASE + SLOT_W'(la[4:0]);
		else
			case (la)
				LOG_EXT_ERROR:    s = 6'h01;
				// The basic and extended self-test logs share one slot so every entry
				// firmware records, 28-bit or 48-bit, is seen in the extended log.
				LOG_SELFTEST_BASE,
				LOG_SELFTEST_EXT: s = 6'h02;
				LOG_POWER_COND:   s = 6'h03;
				LOG_QUEUED_ERROR: s = 6'h04;
				LOG_LINK_EVENTS:  s = 6'h05;
				LOG_QUEUE_MGMT:   s = 6'h06;
				LOG_REBUILD:      s = 6'h07;
				LOG_STREAM_WRITE: s = 6'h08;
				LOG_STREAM_READ:  s = 6'h09;
				LOG_IDENTIFY:     s = 6'h0A;
				default:          s = 6'h00;
			endcase
		return s;
	endfunction

	assign accept     = ce && (state == S_IDLE) && cmd_strobe && (cmd_code == CMD_READ_LOG_EXT);
	assign log_len    = log_size(log_addr, feature_enable);
	assign bad_params = (sect_count == NO_SECTORS) || (log_len == NO_SECTORS) ||
		(start_sect >= log_len) || (sect_count > (log_len - start_sect));
	assign issue      = ce && (state == S_FETCH) && !pend && fill.ready && !media_fault;
	assign last_word  = (widx == LAST_WORD);
	assign rd_addr    = {log_slot(log_addr), sect[3:0], widx};
	assign in_block   = (state == S_BLOCK);
	assign fill.valid = pend;
	assign fill.data  = pend_dir ? dir_q : mem_q;

	log_word_store u_store (
		.clk     (clk),
		.ce      (ce),
		.wr_en   (log_wr_en),
		.wr_addr (log_wr_addr),
		.wr_data (log_wr_data),
		.rd_en   (issue),
		.rd_addr (rd_addr),
		.rd_data (mem_q)
	);

	word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.in_s      (fill),
		.out_valid (data_valid),
		.out_data  (data_word),
		.out_ready (data_ready)
	);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			log_addr   <= '0;
			start_sect <= '0;
			sect_count <= '0;
		end
		else if (accept)
		begin
			log_addr   <= sector_cur;
			start_sect <= {cyl_low_prev, cyl_low_cur};
			sect_count <= {count_prev, count_cur};
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= S_IDLE;
		else if (ce)
		begin
			unique case (state)
				S_IDLE:
					if (accept)
						state <= S_CHECK;
				S_CHECK:
					state <= bad_params ? S_IDLE : S_BLOCK;
				S_BLOCK:
					state <= S_FETCH;
				S_FETCH:
					if (media_fault)
						state <= S_DRAIN;
					else if (issue && last_word)
						state <= (remain == PLAIN_SECTORS) ? S_DRAIN : S_BLOCK;
				S_DRAIN:
					if (!pend && fill.drained)
						state <= S_IDLE;
				default:
					state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sect   <= '0;
			remain <= '0;
			widx   <= '0;
		end
		else if (ce)
		begin
			if (state == S_CHECK)
			begin
				sect   <= start_sect;
				remain <= sect_count;
				widx   <= '0;
			end
			else if (issue)
			begin
				widx <= widx + 1'b1;
				if (last_word)
				begin
					sect   <= sect + 1'b1;
					remain <= remain - 1'b1;
				end
			end
		end
	end

	// A directory word is computed in the issue cycle so it lines up with the store read.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend     <= 1'b0;
			pend_dir <= 1'b0;
			pend_ver <= 1'b0;
			dir_q    <= '0;
		end
		else if (ce)
		begin
			pend     <= issue;
			pend_dir <= (log_addr == LOG_DIRECTORY);
			pend_ver <= issue && (log_addr == LOG_DIRECTORY) && (widx == 8'h00);
			if (widx == 8'h00)
				dir_q <= DIR_VERSION;
			else
				dir_q <= log_size(widx, feature_enable);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else if (ce)
			irq <= in_block;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			unc_seen <= 1'b0;
		else if (ce)
		begin
			if (accept)
				unc_seen <= 1'b0;
			else if ((state == S_FETCH) && media_fault)
				unc_seen <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			command_error_flags      <= ERROR_RESET;
			command_completion_flags <= STATUS_RESET;
		end
		else if (ce)
		begin
			if (accept)
			begin
				command_error_flags              <= '0;
				command_completion_flags         <= '0;
				command_completion_flags[ST_BSY] <= 1'b1;
			end
			else if ((state == S_CHECK) && bad_params)
			begin
				command_error_flags[ERR_ABT]     <= 1'b1;
				command_error_flags[ERR_IDN]     <= (log_len != NO_SECTORS) && (start_sect >= log_len);
				command_completion_flags         <= STATUS_RESET;
				command_completion_flags[ST_ERR] <= 1'b1;
			end
			else if (state == S_CHECK)
			begin
				command_completion_flags         <= STATUS_RESET;
				command_completion_flags[ST_DRQ] <= 1'b1;
			end
			else if ((state == S_DRAIN) && !pend && fill.drained)
			begin
				command_error_flags[ERR_UNC]     <= unc_seen;
				command_completion_flags         <= STATUS_RESET;
				command_completion_flags[ST_ERR] <= unc_seen;
			end
		end
	end

	sequence accepted_s;
		accept ##1 ce;
	endsequence

	a_accept_busy: assert property (@(posedge clk) disable iff (!rst_n)
		accept |=> (state == S_CHECK) && command_completion_flags[ST_BSY])
		else $error("Accepted command did not go busy.");
	a_unsupported_abort: assert property (@(posedge clk) disable iff (!rst_n)
		(accept && !log_ok(sector_cur, feature_enable)) ##0 accepted_s |=>
		(state == S_IDLE) && command_error_flags[ERR_ABT] && command_completion_flags[ST_ERR])
		else $error("Unserved log was not aborted.");
	a_zero_count_abort: assert property (@(posedge clk) disable iff (!rst_n)
		(accept && (count_cur == 8'h00) && (count_prev == 8'h00)) ##0 accepted_s |=>
		command_error_flags[ERR_ABT] && !command_completion_flags[ST_DRQ])
		else $error("Zero sector count was not aborted.");
	a_irq_per_block: assert property (@(posedge clk) disable iff (!rst_n)
		(in_block && ce) |=> irq ##1 !irq)
		else $error("Block start gave no single interrupt pulse.");
	a_irq_only_block: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(irq) |-> $past(in_block))
		else $error("Interrupt raised outside a block start.");
	a_dir_version: assert property (@(posedge clk) disable iff (!rst_n)
		pend_ver |-> fill.valid && (fill.data == DIR_VERSION))
		else $error("Directory version word is wrong.");
	a_start_sector: assert property (@(posedge clk) disable iff (!rst_n)
		($past(state == S_CHECK) && in_block) |-> (sect == start_sect) && (widx == 8'h00))
		else $error("Transfer did not begin at the start sector.");
	a_done_status: assert property (@(posedge clk) disable iff (!rst_n)
		($past(state == S_DRAIN) && (state == S_IDLE)) |->
		!command_completion_flags[ST_BSY] && !command_completion_flags[ST_DF] &&
		command_completion_flags[ST_RDY] && command_completion_flags[ST_DSC] &&
		(command_completion_flags[ST_ERR] == command_error_flags[ERR_UNC]))
		else $error("Completion flags are wrong.");
endmodule

//--- hw/word_fifo.sv
// Word FIFO with a registered output stage.
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	word_stream_if.snk            in_s,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	logic [WIDTH-1:0]         store [DEPTH];
	logic [$clog2(DEPTH)-1:0] wp;
	logic [$clog2(DEPTH)-1:0] rp;
	logic [$clog2(DEPTH):0]   cnt;
	logic                     push;
	logic                     pop;

	assign in_s.ready   = (cnt != ($clog2(DEPTH)+1)'(DEPTH));
	assign in_s.drained = (cnt == '0) && !out_valid;
	assign push = in_s.valid && in_s.ready;
	assign pop  = (cnt != '0) && (!out_valid || out_ready);

	always_ff @(posedge clk)
	begin
		if (ce && push)
			store[wp] <= in_s.data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end
		else if (ce)
		begin
			if (push)
				wp <= wp + 1'b1;
			if (pop)
				rp <= rp + 1'b1;
			cnt <= cnt + (($clog2(DEPTH)+1)'(push)) - (($clog2(DEPTH)+1)'(pop));
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end
		else if (ce)
		begin
			if (pop)
			begin
				out_valid <= 1'b1;
				out_data  <= store[rp];
			end
			else if (out_ready)
				out_valid <= 1'b0;
		end
	end

	// The source offers each word for one cycle only, so an offer while full loses it.
	a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_n)
		in_s.valid |-> in_s.ready)
		else $error("Word offered to a full FIFO.");
endmodule
